// ===== src/ubc_uart0_buffer.sv
// Shared data buffer of the serial port: transmit shifter, receive latch, line logic.
// Assumes the special-function bus is synchronous to ref_clk_i and that
// prescale, clock select and reload come from registers on the same clock.
`timescale 1ns/1ps

module ubc_uart0_buffer
	import ubc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire ubc_sfr_req_t sfr_req_i,
	output logic [7:0] sfr_rdata_o,
	input wire logic [1:0] timer_prescale_select_i,
	input wire logic baud_timer_clock_select_i,
	input wire logic [7:0] baud_reload_i,
	input wire logic rx_i,
	output logic tx_o,
	output logic tx_busy_o,
	output logic rx_valid_o
);

	// ****************************************************************
	// Baud clock
	// ****************************************************************
	logic ovf;
	logic bit_tick;

	ubc_baud_gen u_baud (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.timer_prescale_select_i(timer_prescale_select_i),
		.baud_timer_clock_select_i(baud_timer_clock_select_i),
		.reload_i(baud_reload_i),
		.ovf_o(ovf),
		.bit_tick_o(bit_tick)
	);

	// ****************************************************************
	// Buffer decode
	// ****************************************************************
	wire buf_hit = (sfr_req_i.addr == UBC_BUF_ADDR);
	wire wr_hit = buf_hit & sfr_req_i.wr;
	wire rd_hit = buf_hit & sfr_req_i.rd;

	logic [7:0] rdata_ff;
	logic [7:0] rx_latch_ff;

	// Reads see only the receive latch; the transmit byte has no read path.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_ff <= UBC_BUF_RESET;
		end else if (rd_hit) begin
			rdata_ff <= rx_latch_ff;
		end
	end

	assign sfr_rdata_o = rdata_ff;

	// ****************************************************************
	// Transmitter
	// ****************************************************************
	logic [9:0] tx_shift_ff;
	logic [3:0] tx_cnt_ff;
	logic tx_busy_ff;
	logic tx_ff;
	wire tx_step = bit_tick & tx_busy_ff & (tx_cnt_ff != 4'h0);
	wire tx_end = bit_tick & tx_busy_ff & (tx_cnt_ff == 4'h0);

	// A write during a frame restarts it; software is expected to wait for idle.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_shift_ff <= 10'h3FF;
			tx_cnt_ff <= 4'h0;
			tx_busy_ff <= 1'b0;
			tx_ff <= 1'b1;
		end else if (wr_hit) begin
			tx_shift_ff <= {1'b1, sfr_req_i.wdata, 1'b0};
			tx_cnt_ff <= UBC_FRAME_BITS;
			tx_busy_ff <= 1'b1;
		end else if (tx_step) begin
			tx_ff <= tx_shift_ff[0];
			tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
			tx_cnt_ff <= tx_cnt_ff - 4'h1;
		end else if (tx_end) begin
			tx_busy_ff <= 1'b0;
		end
	end

	assign tx_o = tx_ff;
	assign tx_busy_o = tx_busy_ff;

	// ****************************************************************
	// Receiver
	// ****************************************************************
	logic rx_meta_ff;
	logic rx_sync_ff;
	ubc_rx_state_t rx_state_ff;
	ubc_rx_state_t nxt_rx_state;
	logic [7:0] rx_shift_ff;
	logic [2:0] rx_cnt_ff;
	logic rx_half_ff;
	logic rx_valid_ff;

	// Start detection is only as fine as one timer overflow, half a bit.
	wire rx_sample = ovf & rx_half_ff;
	wire rx_accept = (rx_state_ff == UBC_RX_STOP) & rx_sample & rx_sync_ff;
	logic rx_prev_ff;
	// Arm only on a falling edge, so a line left low by a bad stop bit is no new start.
	wire rx_fall = rx_prev_ff & ~rx_sync_ff;

	always_comb begin
		nxt_rx_state = rx_state_ff;
		case (rx_state_ff)
			UBC_RX_IDLE: begin
				if (rx_fall) begin
					nxt_rx_state = UBC_RX_START;
				end
			end
			UBC_RX_START: begin
				if (ovf) begin
					nxt_rx_state = rx_sync_ff ? UBC_RX_IDLE : UBC_RX_DATA;
				end
			end
			UBC_RX_DATA: begin
				if (rx_sample && rx_cnt_ff == UBC_LAST_DATA_BIT) begin
					nxt_rx_state = UBC_RX_STOP;
				end
			end
			UBC_RX_STOP: begin
				if (rx_sample) begin
					nxt_rx_state = UBC_RX_IDLE;
				end
			end
			default: nxt_rx_state = UBC_RX_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_meta_ff <= 1'b1;
			rx_sync_ff <= 1'b1;
			rx_prev_ff <= 1'b1;
			rx_state_ff <= UBC_RX_IDLE;
			rx_shift_ff <= 8'h00;
			rx_cnt_ff <= 3'h0;
			rx_half_ff <= 1'b0;
			rx_valid_ff <= 1'b0;
			rx_latch_ff <= UBC_BUF_RESET;
		end else begin
			rx_meta_ff <= rx_i;
			rx_sync_ff <= rx_meta_ff;
			rx_prev_ff <= rx_sync_ff;
			rx_state_ff <= nxt_rx_state;
			rx_valid_ff <= rx_accept;
			if (rx_state_ff == UBC_RX_START) begin
				rx_half_ff <= 1'b0;
				rx_cnt_ff <= 3'h0;
			end else if (ovf) begin
				rx_half_ff <= ~rx_half_ff;
			end
			if (rx_state_ff == UBC_RX_DATA && rx_sample) begin
				rx_shift_ff <= {rx_sync_ff, rx_shift_ff[7:1]};
				rx_cnt_ff <= rx_cnt_ff + 3'h1;
			end
			if (rx_accept) begin
				rx_latch_ff <= rx_shift_ff;
			end
		end
	end

	assign rx_valid_o = rx_valid_ff;

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_write_loads;
		@(posedge ref_clk_i) disable iff (rst_i)
		wr_hit |=> tx_shift_ff == {1'b1, $past(sfr_req_i.wdata), 1'b0} && tx_cnt_ff == UBC_FRAME_BITS;
	endproperty
	a_write_loads: assert property (p_write_loads)
		else $error("write did not load the shifter");

	sequence s_start_bit;
		tx_busy_ff ##1 (tx_busy_ff && tx_step && !wr_hit);
	endsequence

	property p_write_starts;
		@(posedge ref_clk_i) disable iff (rst_i)
		wr_hit |=> tx_busy_ff;
	endproperty
	a_write_starts: assert property (p_write_starts)
		else $error("write did not start a frame");

	property p_start_bit_low;
		@(posedge ref_clk_i) disable iff (rst_i)
		tx_cnt_ff == UBC_FRAME_BITS && !wr_hit ##0 s_start_bit |=> !tx_ff;
	endproperty
	a_start_bit_low: assert property (p_start_bit_low)
		else $error("start bit not driven low");

	property p_idle_high;
		@(posedge ref_clk_i) disable iff (rst_i)
		!tx_busy_ff |-> tx_ff;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("line not high while idle");

	property p_read_latch;
		@(posedge ref_clk_i) disable iff (rst_i)
		rd_hit |=> sfr_rdata_o == $past(rx_latch_ff);
	endproperty
	a_read_latch: assert property (p_read_latch)
		else $error("read did not return receive latch");

	property p_write_spares_latch;
		@(posedge ref_clk_i) disable iff (rst_i)
		wr_hit && !rx_accept |=> rx_latch_ff == $past(rx_latch_ff);
	endproperty
	a_write_spares_latch: assert property (p_write_spares_latch)
		else $error("write altered latch");

	property p_idle_needs_fall;
		@(posedge ref_clk_i) disable iff (rst_i)
		rx_state_ff == UBC_RX_IDLE && !rx_fall |=> rx_state_ff == UBC_RX_IDLE;
	endproperty
	a_idle_needs_fall: assert property (p_idle_needs_fall)
		else $error("receiver armed without a falling edge");

endmodule

// ===== src/ubc_pkg.sv
// Shared constants and types for the serial port data buffer and baud clock.
// Assumes a single core clock domain with one asynchronous active-high reset.
//
// Operation
// - One buffer address reaches two stores: transmit shifter on write, receive latch on read.
// - A written byte goes into the transmit shifter and stays there for serial output.
// - Every byte write to the buffer starts a transmission with no other command.
// - A buffer read returns the receive latch, never the byte waiting to go out.
// - Clock select clear: prescale 00 divides by 12, 01 by 4, 10 by 48.
// - Clock select set: baud timer runs on undivided core clock, prescale ignored.
package ubc_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] UBC_BUF_ADDR = 8'h99;
	localparam logic [7:0] UBC_BUF_RESET = 8'h00;

	// ****************************************************************
	// Prescale encodings and divisors
	// ****************************************************************
	localparam logic [1:0] UBC_PRE_DIV12 = 2'h0;
	localparam logic [1:0] UBC_PRE_DIV4 = 2'h1;
	localparam logic [1:0] UBC_PRE_DIV48 = 2'h2;
	localparam logic [5:0] UBC_DIV12 = 6'h0C;
	localparam logic [5:0] UBC_DIV4 = 6'h04;
	localparam logic [5:0] UBC_DIV48 = 6'h30;
	localparam logic [5:0] UBC_DIV1 = 6'h01;
	localparam logic [7:0] UBC_TIMER_TOP = 8'hFF;

	// ****************************************************************
	// Frame layout
	// ****************************************************************
	localparam logic [3:0] UBC_FRAME_BITS = 4'hA;
	localparam logic [2:0] UBC_LAST_DATA_BIT = 3'h7;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} ubc_sfr_req_t;

	typedef enum logic [1:0] {
		UBC_RX_IDLE,
		UBC_RX_START,
		UBC_RX_DATA,
		UBC_RX_STOP
	} ubc_rx_state_t;

endpackage

// ===== src/ubc_baud_gen.sv
// Baud timer with prescaler; gives the overflow pulse and the bit pulse.
// Assumes the clock select, prescale and reload inputs come from core-clock logic.
`timescale 1ns/1ps

module ubc_baud_gen
	import ubc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [1:0] timer_prescale_select_i,
	input wire logic baud_timer_clock_select_i,
	input wire logic [7:0] reload_i,
	output logic ovf_o,
	output logic bit_tick_o
);

	// ****************************************************************
	// Prescaler
	// ****************************************************************
	function automatic logic [5:0] div_of(input logic [1:0] sel);
		case (sel)
			UBC_PRE_DIV12: div_of = UBC_DIV12;
			UBC_PRE_DIV4: div_of = UBC_DIV4;
			UBC_PRE_DIV48: div_of = UBC_DIV48;
			default: div_of = UBC_DIV1;
		endcase
	endfunction

	logic [5:0] pre_cnt_ff;
	logic [7:0] timer_ff;
	logic ovf_ff;
	logic phase_ff;
	logic bit_tick_ff;
	wire [5:0] div_sel = div_of(timer_prescale_select_i);
	// Compare with >= so a divisor change mid-count cannot stall the prescaler.
	wire pre_tick = (pre_cnt_ff >= (div_sel - 6'h01));
	wire advance = baud_timer_clock_select_i | pre_tick;
	wire at_top = (timer_ff == UBC_TIMER_TOP);
	wire [5:0] nxt_pre_cnt = pre_tick ? 6'h00 : pre_cnt_ff + 6'h01;
	wire [7:0] nxt_timer = at_top ? reload_i : timer_ff + 8'h01;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pre_cnt_ff <= 6'h00;
			timer_ff <= 8'h00;
			ovf_ff <= 1'b0;
			phase_ff <= 1'b0;
			bit_tick_ff <= 1'b0;
		end else begin
			pre_cnt_ff <= nxt_pre_cnt;
			if (advance) begin
				timer_ff <= nxt_timer;
			end
			ovf_ff <= advance & at_top;
			if (ovf_ff) begin
				phase_ff <= ~phase_ff;
			end
			bit_tick_ff <= ovf_ff & phase_ff;
		end
	end

	assign ovf_o = ovf_ff;
	assign bit_tick_o = bit_tick_ff;

	// ****************************************************************
	// Checks
	// ****************************************************************
	wire cfg_div4 = ~baud_timer_clock_select_i & (timer_prescale_select_i == UBC_PRE_DIV4);

	sequence s_div4_held;
		cfg_div4 [*4];
	endsequence

	property p_div4_period;
		@(posedge ref_clk_i) disable iff (rst_i)
		pre_tick ##1 s_div4_held |-> pre_tick && !$past(pre_tick, 1) && !$past(pre_tick, 3);
	endproperty
	a_div4_period: assert property (p_div4_period)
		else $error("prescale 01 is not divide by 4");

	property p_direct_clock;
		@(posedge ref_clk_i) disable iff (rst_i)
		!rst_i && baud_timer_clock_select_i && !at_top |=> timer_ff == $past(timer_ff) + 8'h01;
	endproperty
	a_direct_clock: assert property (p_direct_clock)
		else $error("timer not advancing on core clock");

	property p_reload;
		@(posedge ref_clk_i) disable iff (rst_i)
		advance && at_top |=> ovf_ff && timer_ff == $past(reload_i);
	endproperty
	a_reload: assert property (p_reload) else $error("timer did not reload on overflow");

	property p_bit_two_ovf;
		@(posedge ref_clk_i) disable iff (rst_i)
		bit_tick_ff |-> $past(ovf_ff) && $past(phase_ff) && !phase_ff;
	endproperty
	a_bit_two_ovf: assert property (p_bit_two_ovf)
		else $error("bit pulse not on every second overflow");

endmodule

// ===== verification/ubc_line_partner.sv
// Remote serial station on the line: decodes frames from tx, sends frames on rx.
// Assumes the bench sets bit_cycles to match the baud configuration.
`timescale 1ns/1ps

module ubc_line_partner (
	input wire logic ref_clk_i,
	input wire logic tx_i,
	output logic rx_o
);
	// ****
	// Line model
	// ****
	int bit_cycles = 4;
	logic [7:0] got_ff = 8'h00;
	logic stop_ok_ff = 1'b0;
	int n_got = 0;

	initial rx_o = 1'b1;

	// Idle high between frames, so the line never shows a stale data bit.
	task automatic send(input logic [7:0] d, input logic stop);
		for (int i = 0; i < 10; i++) begin
			@(posedge ref_clk_i);
			rx_o <= (i == 0) ? 1'b0 : (i == 9) ? stop : d[i-1];
			repeat (bit_cycles - 1) @(posedge ref_clk_i);
		end
		@(posedge ref_clk_i);
		rx_o <= 1'b1;
		repeat (4 * bit_cycles) @(posedge ref_clk_i);
	endtask

	// Samples in mid bit, LSB first, as a real receiver would.
	initial begin
		forever begin
			@(negedge tx_i);
			repeat (bit_cycles / 2) @(posedge ref_clk_i);
			for (int i = 0; i < 8; i++) begin
				repeat (bit_cycles) @(posedge ref_clk_i);
				got_ff[i] = tx_i;
			end
			repeat (bit_cycles) @(posedge ref_clk_i);
			stop_ok_ff = tx_i;
			n_got++;
		end
	end
endmodule

// ===== verification/uart0_data_buffer_and_baud_clock_bench.sv
// Self-checking bench for the serial data buffer and baud clock.
// Assumes the line partner model and the buffer top with its package.
`timescale 1ns/1ps

module uart0_data_buffer_and_baud_clock_bench;
	import ubc_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	ubc_sfr_req_t req = '0;
	logic [1:0] pre = 2'h0;
	logic sel = 1'b1;
	logic [7:0] rdata;
	logic tx, busy, rx_valid, rx;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int n_valid = 0;

	always #10 ref_clk_i = ~ref_clk_i;

	ubc_uart0_buffer u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sfr_req_i(req),
		.sfr_rdata_o(rdata), .timer_prescale_select_i(pre), .baud_timer_clock_select_i(sel),
		.baud_reload_i(8'hFE), .rx_i(rx), .tx_o(tx), .tx_busy_o(busy), .rx_valid_o(rx_valid));
	ubc_line_partner u_part (.ref_clk_i(ref_clk_i), .tx_i(tx), .rx_o(rx));

	// ****
	// Shared tasks
	// ****
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge ref_clk_i);
		req <= '{addr: a, wr: w, rd: ~w, wdata: d};
		@(posedge ref_clk_i);
		req <= '0;
		#1;
	endtask

	task automatic read_buf(input logic [7:0] exp);
		bus(UBC_BUF_ADDR, 1'b0, 8'h00);
		check(rdata, exp);
	endtask

	always @(posedge ref_clk_i) begin
		cycles++;
		if (rx_valid === 1'b1) n_valid++;
		if (cycles == 60000) begin
			num_errors++;
			conclude();
		end
	end

	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		check(tx, 1'b1);
		check(busy, 1'b0);
		read_buf(UBC_BUF_RESET);
		bus(8'h98, 1'b1, 8'h5A);
		@(posedge ref_clk_i);
		#1;
		check(busy, 1'b0);
	endtask

	// Start bit then bit0=1 gives one low bit period to time exactly.
	task automatic t_tx(input logic s, input logic [1:0] p, input int div, input logic [7:0] d,
		input logic [7:0] lat);
		int n;
		int low;
		int g;
		n = 0;
		low = 0;
		g = u_part.n_got;
		@(posedge ref_clk_i);
		sel <= s;
		pre <= p;
		u_part.bit_cycles = 4 * div;
		bus(UBC_BUF_ADDR, 1'b1, d);
		check(busy, 1'b1);
		read_buf(lat);
		while (tx !== 1'b0 && n < 20000) begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end
		while (tx === 1'b0 && low < 20000) begin
			@(posedge ref_clk_i);
			#1;
			low++;
		end
		check(low, 4 * div);
		n = 0;
		while (busy === 1'b1 && n < 20000) begin
			@(posedge ref_clk_i);
			n++;
		end
		check(busy, 1'b0);
		repeat (8) @(posedge ref_clk_i);
		check(u_part.n_got - g, 1);
		check(u_part.got_ff, d);
		check(u_part.stop_ok_ff, 1'b1);
	endtask

	task automatic t_rx(input logic [7:0] d, input logic stop, input logic [7:0] lat);
		int v;
		@(posedge ref_clk_i);
		sel <= 1'b1;
		u_part.bit_cycles = 4;
		v = n_valid;
		u_part.send(d, stop);
		// Give a false restart after a bad stop bit time to show up.
		repeat (48) @(posedge ref_clk_i);
		check(n_valid - v, stop ? 1 : 0);
		read_buf(lat);
	endtask

	initial begin
		repeat (16) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_tx(1'b0, UBC_PRE_DIV12, 12, 8'hB5, 8'h00);
		t_rx(8'h3C, 1'b1, 8'h3C);
		t_tx(1'b0, UBC_PRE_DIV4, 4, 8'h4B, 8'h3C);
		t_tx(1'b0, UBC_PRE_DIV48, 48, 8'hA7, 8'h3C);
		t_tx(1'b1, UBC_PRE_DIV48, 1, 8'h6D, 8'h3C);
		t_tx(1'b0, 2'h3, 1, 8'hC9, 8'h3C);
		t_rx(8'h55, 1'b0, 8'h3C);
		conclude();
	end
endmodule
